// [core/half_bridge_input_decoder.v]
`timescale 1ns/1ps
`include "bridge_defs.vh"

// Operation
// - Field 00 or strap at ground selects the six-input scheme.
// - Six-input: high alone drives high gate, low alone low gate, equal floats.
// - Field 01 or strap through 47k selects the three-input scheme.
// - Three-input: low-side input low turns both gates off, phase floats.
// - Three-input, low-side high: high-side input picks high or low gate.
// - Serial access accepted from 1 ms after enable with supply good.
// - Any fault drives the active-low fault output; details held readable.
// - Dead time inserted between one gate off and the other on.
// - Field 10 or open strap selects the single-input table scheme.
module half_bridge_input_decoder #(
    parameter READY_CNT = `READY_CYCLES
) (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Scheme select
    input  wire       use_strap_i,
    input  wire [1:0] scheme_field_i,
    input  wire [1:0] strap_level_i,
    // Controller inputs
    input  wire [2:0] high_side_control_in_i,
    input  wire [2:0] low_side_control_in_i,
    // Supply, enable and faults
    input  wire       enable_i,
    input  wire       supply_lockout_i,
    input  wire [3:0] fault_src_i,
    input  wire       fault_clear_i,
    // Gate commands
    output wire [2:0] upper_gate_cmd_o,
    output wire [2:0] lower_gate_cmd_o,
    // Status
    output reg  [1:0] scheme_o,
    output reg        serial_ready_o,
    output reg        fault_flag_n_o,
    output reg  [3:0] fault_detail_o
);

    // Three-stage synchroniser on the enable, lockout and controller input pins
    reg [7:0] s1_q;
    reg [7:0] s2_q;
    reg [7:0] s3_q;
    reg [7:0] stable_q;
    wire [7:0] raw = {enable_i, supply_lockout_i, high_side_control_in_i,
                      low_side_control_in_i};
    integer k;

    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_q     <= 8'h00;
            s2_q     <= 8'h00;
            s3_q     <= 8'h00;
            stable_q <= 8'h00;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (k = 0; k < 8; k = k + 1) begin
                if (s2_q[k] == s3_q[k])
                    stable_q[k] <= s3_q[k];
            end
        end
    end

    wire [2:0] lo_s  = stable_q[2:0];
    wire [2:0] hi_s  = stable_q[5:3];
    wire       lock_s = stable_q[6];
    wire       en_s   = stable_q[7];

    // Scheme select; strap wins when the hardware variant is strapped
    function [1:0] strap_map;
        input [1:0] lvl;
        begin
            case (lvl)
                `STRAP_GND:  strap_map = `SCHEME_SIX;
                `STRAP_47K:  strap_map = `SCHEME_THREE;
                `STRAP_OPEN: strap_map = `SCHEME_SINGLE;
                default:     strap_map = `SCHEME_INDEP;
            endcase
        end
    endfunction

    // Scheme is sampled continuously; changing it mid-switching is on the controller
    always @(posedge clk_i) begin
        if (rst_i)
            scheme_o <= `SCHEME_SIX;
        else
            scheme_o <= use_strap_i ? strap_map(strap_level_i) : scheme_field_i;
    end

    // Per-phase decode; one function serves all three legs
    function [1:0] leg_want;
        input [1:0] sch;
        input       hi_in;
        input       lo_in;
        begin
            case (sch)
                `SCHEME_SIX:   leg_want = {hi_in && !lo_in, lo_in && !hi_in};
                `SCHEME_THREE: leg_want = {lo_in && hi_in, lo_in && !hi_in};
                // Table and independent schemes live elsewhere; gates stay off
                default:       leg_want = 2'h0;
            endcase
        end
    endfunction

    reg  [2:0] want_hi;
    reg  [2:0] want_lo;
    integer p;

    always @* begin
        want_hi = 3'h0;
        want_lo = 3'h0;
        for (p = 0; p < 3; p = p + 1) begin
            {want_hi[p], want_lo[p]} = leg_want(scheme_o, hi_s[p], lo_s[p]);
        end
    end

    // Faults and lockout force every gate off
    wire kill = lock_s || !en_s || !fault_flag_n_o;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : leg
            phase_leg u_leg (
                .clk_i            (clk_i),
                .rst_i            (rst_i),
                .want_hi_i        (want_hi[g]),
                .want_lo_i        (want_lo[g]),
                .kill_i           (kill),
                .upper_gate_cmd_o (upper_gate_cmd_o[g]),
                .lower_gate_cmd_o (lower_gate_cmd_o[g])
            );
        end
    endgenerate

    // Ready timer after enable with supply good
    reg [31:0] ready_q;

    always @(posedge clk_i) begin
        if (rst_i || lock_s || !en_s) begin
            ready_q        <= 32'h0;
            serial_ready_o <= 1'b0;
        end else if (ready_q >= READY_CNT - 1) begin
            serial_ready_o <= 1'b1;
        end else begin
            ready_q <= ready_q + 32'h1;
        end
    end

    // Sticky fault detail; a new fault wins over a clear
    reg [3:0] fault_d;

    always @* begin
        fault_d = fault_clear_i ? 4'h0 : fault_detail_o;
        fault_d = fault_d | fault_src_i;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            fault_detail_o <= 4'h0;
            fault_flag_n_o <= 1'b1;
        end else begin
            fault_detail_o <= fault_d;
            fault_flag_n_o <= ~(|fault_d);
        end
    end

endmodule // half_bridge_input_decoder

// [core/phase_leg.v]
`timescale 1ns/1ps
`include "bridge_defs.vh"

module phase_leg #(
    parameter DEAD_W   = 8,
    parameter [DEAD_W-1:0] DEAD_CNT = `DEAD_CYCLES
) (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Requested gate levels
    input  wire want_hi_i,
    input  wire want_lo_i,
    input  wire kill_i,
    // Gate commands
    output reg  upper_gate_cmd_o,
    output reg  lower_gate_cmd_o
);

    reg [DEAD_W-1:0] dead_q;

    // Both gates drop at once; the new one waits out the dead time
    always @(posedge clk_i) begin
        if (rst_i || kill_i) begin
            upper_gate_cmd_o <= 1'b0;
            lower_gate_cmd_o <= 1'b0;
            dead_q           <= DEAD_CNT;
        end else if ((upper_gate_cmd_o && !want_hi_i) || (lower_gate_cmd_o && !want_lo_i)) begin
            upper_gate_cmd_o <= 1'b0;
            lower_gate_cmd_o <= 1'b0;
            dead_q           <= DEAD_CNT;
        end else if (dead_q != {DEAD_W{1'b0}}) begin
            dead_q <= dead_q - {{(DEAD_W-1){1'b0}}, 1'b1};
        end else begin
            upper_gate_cmd_o <= want_hi_i && !want_lo_i;
            lower_gate_cmd_o <= want_lo_i && !want_hi_i;
        end
    end

endmodule // phase_leg

// [pkg/bridge_defs.vh]
`ifndef BRIDGE_DEFS_VH
`define BRIDGE_DEFS_VH

// Scheme field encodings
`define SCHEME_SIX          2'h0
`define SCHEME_THREE        2'h1
`define SCHEME_SINGLE       2'h2
`define SCHEME_INDEP        2'h3

// Strap decode levels (external comparator result)
`define STRAP_GND           2'h0
`define STRAP_47K           2'h1
`define STRAP_OPEN          2'h2

// Timing
`define CLK_PERIOD_NS       10
`define READY_TIME_MS       1
`define READY_CYCLES        ((`READY_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define DEAD_TIME_NS        100
`define DEAD_CYCLES         ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [test/bridge_monitor.sv]
`timescale 1ns/1ps
module bridge_monitor (
    input wire       clk_i, rst_i, use_strap_i, enable_i, serial_ready_o, fault_flag_n_o,
    input wire [1:0] scheme_field_i, strap_level_i, scheme_o,
    input wire [2:0] high_side_control_in_i, low_side_control_in_i,
    input wire [2:0] upper_gate_cmd_o, lower_gate_cmd_o,
    input wire [3:0] fault_src_i
);
    wire [2:0] hi = high_side_control_in_i;
    wire [2:0] lo = low_side_control_in_i;
    wire [2:0] up = upper_gate_cmd_o;
    wire [2:0] dn = lower_gate_cmd_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Six edges of steady input outlast the synchroniser
    sequence s_eq; (scheme_o == 2'h0 && hi[1] == lo[1])[*6]; endsequence
    sequence s_flt; (scheme_o == 2'h1 && !lo[0])[*6]; endsequence
    sequence s_hi; (scheme_o == 2'h1 && lo[0] && hi[0])[*6]; endsequence
    property p_eq; s_eq |-> !up[1] && !dn[1]; endproperty
    a_eq: assert property (p_eq) else $error("equal inputs drive a gate");
    property p_flt; s_flt |-> !up[0] && !dn[0]; endproperty
    a_flt: assert property (p_flt) else $error("float not honoured");
    property p_hi; s_hi |-> !dn[0]; endproperty
    a_hi: assert property (p_hi) else $error("low gate on with high level");
    property p_shoot; (up & dn) == 3'h0; endproperty
    a_shoot: assert property (p_shoot) else $error("both gates on");
    property p_dead; $rose(up[0]) |-> !$past(dn[0], 5); endproperty
    a_dead: assert property (p_dead) else $error("dead time short");
    property p_fault; |fault_src_i |=> !fault_flag_n_o; endproperty
    a_fault: assert property (p_fault) else $error("fault not flagged");
    property p_kill; !fault_flag_n_o |=> (up | dn) == 3'h0; endproperty
    a_kill: assert property (p_kill) else $error("gates on during fault");
    property p_field; !use_strap_i |=> scheme_o == $past(scheme_field_i); endproperty
    a_field: assert property (p_field) else $error("scheme field ignored");
    property p_strap; use_strap_i && strap_level_i == 2'h1 |=> scheme_o == 2'h1; endproperty
    a_strap: assert property (p_strap) else $error("strap 47k ignored");
    property p_ready; $rose(serial_ready_o) |-> $past(enable_i, 8); endproperty
    a_ready: assert property (p_ready) else $error("ready too early");
endmodule // bridge_monitor
bind half_bridge_input_decoder bridge_monitor mon (.*);

// [test/pwm_ctl_model.sv]
`timescale 1ns/1ps
module pwm_ctl_model (
    input  wire       clk_i,
    input  wire [1:0] mode_i,
    input  wire [2:0] lvl_i,
    input  wire [2:0] flt_i,
    output reg  [2:0] hi_o,
    output reg  [2:0] lo_o
);
    initial {hi_o, lo_o} = 6'h00;
    // Falling-edge launch keeps pins away from the sampling edge
    always @(negedge clk_i) begin
        if (mode_i == 2'h1) begin
            hi_o <= lvl_i;
            lo_o <= ~flt_i;
        end else begin
            hi_o <= lvl_i | flt_i;
            lo_o <= ~lvl_i | flt_i;
        end
    end
endmodule // pwm_ctl_model

// [test/test_half_bridge_input_decoder.sv]
`timescale 1ns/1ps
module test_half_bridge_input_decoder;
    reg         clk_i, rst_i, use_strap_i, enable_i, fault_clear_i, supply_lockout_i;
    reg  [1:0]  scheme_field_i, strap_level_i;
    reg  [2:0]  lvl, flt;
    reg  [3:0]  fault_src_i;
    reg  [13:0] rows [0:5];
    wire [2:0]  hi, lo, up, dn;
    wire [1:0]  scheme_o;
    wire        ready, flag_n;
    wire [3:0]  detail;
    integer     fail_count = 0, n_checks = 0, i;
    pwm_ctl_model ctl (.clk_i(clk_i), .mode_i(scheme_field_i), .lvl_i(lvl), .flt_i(flt),
        .hi_o(hi), .lo_o(lo));
    half_bridge_input_decoder #(.READY_CNT(20)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .use_strap_i(use_strap_i), .scheme_field_i(scheme_field_i),
        .strap_level_i(strap_level_i), .high_side_control_in_i(hi),
        .low_side_control_in_i(lo), .enable_i(enable_i), .supply_lockout_i(supply_lockout_i),
        .fault_src_i(fault_src_i), .fault_clear_i(fault_clear_i), .upper_gate_cmd_o(up),
        .lower_gate_cmd_o(dn), .scheme_o(scheme_o), .serial_ready_o(ready),
        .fault_flag_n_o(flag_n), .fault_detail_o(detail));
    task chk(input [7:0] s, input [7:0] e); begin
        n_checks = n_checks + 1;
        if (s !== e) begin
            $display("FAIL %0t %h %h", $time, s, e);
            fail_count = fail_count + 1;
        end
    end endtask
    task results; begin
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    end endtask
    task wt(input integer n); repeat (n) @(negedge clk_i); endtask
    initial begin clk_i = 0; forever #5 clk_i = ~clk_i; end
    initial begin #20000; fail_count = fail_count + 1; results; end
    initial begin
        rows[0] = {2'h0, 3'h5, 3'h0, 3'h5, 3'h2};
        rows[1] = {2'h0, 3'h5, 3'h2, 3'h5, 3'h0};
        rows[2] = {2'h1, 3'h3, 3'h0, 3'h3, 3'h4};
        rows[3] = {2'h1, 3'h3, 3'h1, 3'h2, 3'h4};
        rows[4] = {2'h2, 3'h3, 3'h0, 3'h0, 3'h0};
        rows[5] = {2'h3, 3'h3, 3'h0, 3'h0, 3'h0};
        {rst_i, enable_i, use_strap_i, fault_clear_i, supply_lockout_i} = 5'h18;
        {scheme_field_i, strap_level_i, lvl, flt, fault_src_i} = 14'h0000;
        wt(2);
        rst_i = 0;
        wt(10);
        chk(ready, 8'h00);
        // Thirty cycles cover synchroniser plus dead time
        for (i = 0; i < 6; i = i + 1) begin
            {scheme_field_i, lvl, flt} = rows[i][13:6];
            wt(30);
            chk({scheme_o, up, dn}, {rows[i][13:12], rows[i][5:0]});
        end
        chk(ready, 8'h01);
        // Gates are parked before the scheme moves
        enable_i = 0;
        wt(6);
        chk({up, dn, ready}, 8'h00);
        use_strap_i = 1;
        for (i = 0; i < 3; i = i + 1) begin
            strap_level_i = i[1:0];
            wt(2);
            chk(scheme_o, i[7:0]);
        end
        {enable_i, use_strap_i, scheme_field_i, lvl, flt} = 10'h238;
        wt(30);
        fault_src_i = 4'h4;
        wt(1);
        fault_src_i = 4'h0;
        chk({flag_n, detail}, 8'h04);
        wt(2);
        chk({up, dn}, 8'h00);
        fault_clear_i = 1;
        wt(1);
        fault_clear_i = 0;
        wt(30);
        chk({flag_n, detail, up}, 8'h87);
        chk(ready, 8'h01);
        supply_lockout_i = 1;
        wt(6);
        chk({up, dn, ready}, 8'h00);
        supply_lockout_i = 0;
        rst_i = 1;
        wt(2);
        chk({up, dn, ready, flag_n}, 8'h01);
        results;
    end
endmodule // test_half_bridge_input_decoder
